// *** rtl/osd_channel_distribution.sv ***
// Channel distribution of character and blanking signals to RGB, primary and secondary.
// Assumes serial pins and video inputs synchronous to clk; AHB-Lite slave for registers.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/100ps
`include "osd_channel_distribution_params.svh"
module osd_channel_distribution
	import osd_channel_distribution_pkg::*;
#(
	parameter logic [7:0] OPTION_WORD = `OPT_DEFAULT,
	parameter int         ROWS        = `ROW_COUNT,
	parameter int         COLS        = `COL_COUNT
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        clkEn,
	input  wire logic        serClk,
	input  wire logic        serCs_b,
	input  wire logic        serData,
	input  wire logic [3:0]  rowIdx,
	input  wire logic [4:0]  colIdx,
	input  wire logic        redChar,
	input  wire logic        greenChar,
	input  wire logic        blueChar,
	input  wire logic        redBlank,
	input  wire logic        greenBlank,
	input  wire logic        blueBlank,
	input  wire logic        secondaryFlag,
	input  wire logic        backgroundEn,
	input  wire logic        background,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic             red_char_out,
	output logic             green_char_out,
	output logic             blue_char_out,
	output logic             rgbBlankOut,
	output logic             primary_char_out,
	output logic             primary_blank_out,
	output logic             secondary_char_out,
	output logic             secondary_blank_out,
	output logic             msbFirst,
	output logic             threeLineUnit,
	output logic             lcOscSelect
);
	initial begin
		if (ROWS != `ROW_COUNT || COLS != `COL_COUNT)
			$error("osd_channel_distribution: rows must be 12 and columns 24");
		if (OPTION_WORD[7] != 1'b0)
			$error("osd_channel_distribution: option bit 7 must be zero");
		if (OPTION_WORD[`OPT_CLK_HI_BIT] == OPTION_WORD[`OPT_CLK_LO_BIT])
			$error("osd_channel_distribution: dot clock bits must differ");
		if (!OPTION_WORD[`OPT_THREE_CH_BIT]
				&& OPTION_WORD[`OPT_FMT_HI_BIT:`OPT_FMT_LO_BIT] != `FMT_A)
			$error("osd_channel_distribution: per-colour set needs option A");
		if (OPTION_WORD[`OPT_THREE_CH_BIT]
				&& OPTION_WORD[`OPT_FMT_HI_BIT:`OPT_FMT_LO_BIT] == 2'h1)
			$error("osd_channel_distribution: format bits 0,1 select no option");
	end

	function automatic dist_fmt_e decodeFmt(input logic [7:0] w);
		if (!w[`OPT_THREE_CH_BIT])
			return FMT_OPT_A;
		case (w[`OPT_FMT_HI_BIT:`OPT_FMT_LO_BIT])
			`FMT_A: return FMT_OPT_A;
			`FMT_B: return FMT_OPT_B;
			`FMT_C: return FMT_OPT_C;
			default: return FMT_BAD;
		endcase
	endfunction

	localparam logic      THREE_CH = OPTION_WORD[`OPT_THREE_CH_BIT];
	localparam dist_fmt_e FMT      = decodeFmt(OPTION_WORD);
	localparam logic [3:0] ROWBITS_IDX = 4'(`ADDR_ROWBITS >> 2);
	localparam logic [3:0] CHCTRL_IDX  = 4'(`ADDR_CHCTRL >> 2);

	// Configuration pins are constant levels of the option word
	always_comb begin
		msbFirst      = OPTION_WORD[`OPT_MSB_FIRST_BIT];
		threeLineUnit = OPTION_WORD[`OPT_THREE_LINE_BIT];
		lcOscSelect   = (OPTION_WORD[`OPT_CLK_HI_BIT:`OPT_CLK_LO_BIT] == `CLK_LC);
	end

	// Serial receiver
	logic [15:0] shift_r;
	logic [4:0]  bitCnt_r;
	logic        serClkPrev_r;
	logic [15:0] lastCmd_r;
	logic        cmdStrobe;
	logic [15:0] cmdWord;
	logic        serRise;

	// Transfer clock is a level sampled by clk, so a rise acts on the first clk edge that samples it high
	assign serRise = serClk && !serClkPrev_r;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			serClkPrev_r <= 1'b0;
		end else if (clkEn) begin
			serClkPrev_r <= serClk;
		end
	end

	// Strobe on the sixteenth bit only when header and zero bits match
	always_comb begin
		if (msbFirst)
			cmdWord = {shift_r[14:0], serData};
		else
			cmdWord = {serData, shift_r[15:1]};
		cmdStrobe = clkEn && !serCs_b && serRise
			&& bitCnt_r == 5'(`OPC_WORD_BITS - 1)
			&& cmdWord[15:8] == `OPC_HEADER
			&& cmdWord[5:4] == 2'h0;
	end

	// Counter restarts whenever select goes high, so a cut frame is dropped
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			bitCnt_r <= 5'h00;
		else if (clkEn && serCs_b)
			bitCnt_r <= 5'h00;
		else if (clkEn && serRise && bitCnt_r == 5'(`OPC_WORD_BITS - 1))
			bitCnt_r <= 5'h00;
		else if (clkEn && serRise)
			bitCnt_r <= bitCnt_r + 5'h01;
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			shift_r <= 16'h0000;
		else if (clkEn && !serCs_b && serRise)
			shift_r <= cmdWord;
	end

	// Last accepted word, kept for software to read back
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			lastCmd_r <= 16'h0000;
		else if (clkEn && cmdStrobe)
			lastCmd_r <= cmdWord;
	end

	// Per-row channel bits
	logic [`ROW_COUNT-1:0] rowPri_r;
	logic [`ROW_COUNT-1:0] rowSec_r;
	logic [`ROW_COUNT-1:0] busRowWr;
	logic [31:0]           busWData;

	// A serial command wins over a bus write to the row bits in the same cycle
	genvar g;
	generate
		for (g = 0; g < `ROW_COUNT; g++) begin : rowBits
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					rowPri_r[g] <= 1'b0;
					rowSec_r[g] <= 1'b0;
				end else if (clkEn) begin
					if (cmdStrobe && cmdWord[`OPC_ROW_MSB:0] == 4'(g)) begin
						rowPri_r[g] <= cmdWord[`OPC_PRI_BIT];
						rowSec_r[g] <= cmdWord[`OPC_SEC_BIT];
					end else if (busRowWr[g]) begin
						rowPri_r[g] <= busWData[g];
						rowSec_r[g] <= busWData[g + 16];
					end
				end
			end
		end
	endgenerate

	// Per-channel display and background enables
	logic [5:0] chCtrl_r;

	// AHB-Lite slave, zero wait states
	logic        wrPend_r;
	logic [3:0]  wrIdx_r;
	logic [31:0] rdData_r;
	logic        accept;

	assign accept    = hsel && hready && htrans[1];
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdData_r;
	assign busWData  = hwdata;

	// Unmapped offsets read zero
	function automatic logic [31:0] readMux(input logic [31:0] a);
		case (a)
			`ADDR_OPTION:  return {24'h000000, OPTION_WORD};
			`ADDR_ROWBITS: return {4'h0, rowSec_r, 4'h0, rowPri_r};
			`ADDR_CHCTRL:  return {26'h0000000, chCtrl_r};
			`ADDR_LASTCMD: return {16'h0000, lastCmd_r};
			default:       return 32'h00000000;
		endcase
	endfunction

	// Address phase is registered; the write lands in the data phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wrPend_r <= 1'b0;
			wrIdx_r  <= 4'h0;
		end else if (clkEn) begin
			wrPend_r <= accept && hwrite && haddr[31:4] == 28'h0000000;
			wrIdx_r  <= haddr[5:2];
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rdData_r <= 32'h00000000;
		else if (clkEn && accept && !hwrite)
			rdData_r <= readMux(haddr);
	end

	always_comb begin
		busRowWr = {`ROW_COUNT{1'b0}};
		if (wrPend_r && wrIdx_r == ROWBITS_IDX && !cmdStrobe)
			busRowWr = {`ROW_COUNT{1'b1}};
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			chCtrl_r <= 6'h3F;
		else if (clkEn && wrPend_r && wrIdx_r == CHCTRL_IDX)
			chCtrl_r <= hwdata[5:0];
	end

	// Distribution
	logic rowOk;
	logic pri;
	logic sec;
	logic leftHalf;
	logic toPri;
	logic toSec;
	logic priChar;
	logic secChar;
	logic priBg;
	logic secBg;
	logic rgbShow;
	logic priShow;
	logic secShow;
	logic anyChar;
	logic anyBlank;
	logic priBlank;
	logic secBlank;
	logic rgbBgOn;
	logic priBgOn;
	logic secBgOn;
	logic bgArea;

	// Display and background enables only exist in the three-channel pin set
	always_comb begin
		rgbShow = THREE_CH ? chCtrl_r[0] : 1'b1;
		priShow = THREE_CH ? chCtrl_r[1] : 1'b1;
		secShow = THREE_CH ? chCtrl_r[2] : 1'b0;
		rgbBgOn = THREE_CH ? chCtrl_r[3] : 1'b0;
		priBgOn = THREE_CH ? chCtrl_r[4] : 1'b1;
		secBgOn = THREE_CH ? chCtrl_r[5] : 1'b0;
	end

	always_comb begin
		rowOk    = rowIdx < 4'(`ROW_COUNT);
		pri      = rowOk && rowPri_r[rowIdx];
		sec      = rowOk && rowSec_r[rowIdx];
		leftHalf = colIdx < 5'(`COL_HALF);
		anyChar  = redChar | greenChar | blueChar;
		anyBlank = redBlank | greenBlank | blueBlank;
		bgArea   = backgroundEn && background;
		// Route the current position to primary, secondary, both or neither
		case (FMT)
			FMT_OPT_A: begin
				toPri = !pri;
				toSec = pri;
			end
			FMT_OPT_B: begin
				toPri = 1'b1;
				toSec = pri;
			end
			// Option C splits a row into column halves when only one of its two bits is set
			FMT_OPT_C: begin
				case ({sec, pri})
					2'b00: begin toPri = 1'b1; toSec = 1'b0; end
					2'b01: begin toPri = leftHalf; toSec = !leftHalf; end
					2'b10: begin toPri = !leftHalf; toSec = leftHalf; end
					default: begin toPri = 1'b0; toSec = 1'b1; end
				endcase
			end
			default: begin
				toPri = 1'b0;
				toSec = 1'b0;
			end
		endcase
		priChar  = toPri && !secondaryFlag && anyChar && priShow;
		secChar  = toSec && secondaryFlag && secShow;
		priBlank = toPri && !secondaryFlag && priShow && anyBlank;
		secBlank = secChar && anyBlank;
		priBg    = bgArea && !secondaryFlag && priBgOn;
		secBg    = bgArea && secondaryFlag && secBgOn && toSec;
	end

	// Colour channel: flagged characters never reach the viewfinder colours
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			red_char_out   <= 1'b0;
			green_char_out <= 1'b0;
			blue_char_out  <= 1'b0;
		end else if (clkEn) begin
			red_char_out   <= redChar && !secondaryFlag && rgbShow;
			green_char_out <= greenChar && !secondaryFlag && rgbShow;
			blue_char_out  <= blueChar && !secondaryFlag && rgbShow;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			primary_char_out  <= 1'b0;
			primary_blank_out <= 1'b0;
		end else if (clkEn) begin
			primary_char_out  <= priChar;
			primary_blank_out <= priBlank || priBg;
		end
	end

	// Common blanking, or blue blanking in the per-colour pin set
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b)
			rgbBlankOut <= 1'b0;
		else if (clkEn && THREE_CH)
			rgbBlankOut <= !secondaryFlag && rgbShow && (anyBlank || (bgArea && rgbBgOn));
		else if (clkEn)
			rgbBlankOut <= blueBlank && !secondaryFlag;
	end

	// Secondary pair, or green and red blanking in the per-colour pin set
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			secondary_char_out  <= 1'b0;
			secondary_blank_out <= 1'b0;
		end else if (clkEn && THREE_CH) begin
			secondary_char_out  <= secChar;
			secondary_blank_out <= secBlank || secBg;
		end else if (clkEn) begin
			secondary_char_out  <= greenBlank && !secondaryFlag;
			secondary_blank_out <= redBlank && !secondaryFlag;
		end
	end
endmodule

// *** rtl/osd_channel_distribution_params.svh ***
// Constants for the on-screen character channel distribution block.
// Assumes inclusion by the package and the design file.
`ifndef OSD_CHANNEL_DISTRIBUTION_PARAMS_SVH
`define OSD_CHANNEL_DISTRIBUTION_PARAMS_SVH
`define OPC_HEADER        8'h9C
`define OPC_SEC_BIT       7
`define OPC_PRI_BIT       6
`define OPC_ROW_MSB       3
`define OPC_WORD_BITS     16
`define ROW_COUNT         12
`define COL_COUNT         24
`define COL_HALF          12
`define OPT_MSB_FIRST_BIT 6
`define OPT_THREE_LINE_BIT 5
`define OPT_THREE_CH_BIT  4
`define OPT_FMT_HI_BIT    3
`define OPT_FMT_LO_BIT    2
`define OPT_CLK_HI_BIT    1
`define OPT_CLK_LO_BIT    0
`define OPT_DEFAULT       8'h6A
`define FMT_A             2'h2
`define FMT_B             2'h0
`define FMT_C             2'h3
`define CLK_LC            2'h2
`define CLK_EXT           2'h1
`define ADDR_OPTION       32'h00000000
`define ADDR_ROWBITS      32'h00000004
`define ADDR_CHCTRL       32'h00000008
`define ADDR_LASTCMD      32'h0000000C
`endif

// *** rtl/osd_channel_distribution_pkg.sv ***
// Types for the on-screen character channel distribution block.
// Assumes the params header sits beside it.
`include "osd_channel_distribution_params.svh"
package osd_channel_distribution_pkg;
	typedef enum logic [1:0] {FMT_OPT_A, FMT_OPT_B, FMT_OPT_C, FMT_BAD} dist_fmt_e;
	typedef enum {RX_IDLE, RX_SHIFT} rx_state_e;
endpackage

// *** test/osd_channel_distribution_checker.sv ***
// Port checker for the channel distribution block.
// Assumes it is bound into the design top; one clock domain.
`timescale 1ns/100ps
module osd_channel_distribution_checker
	import osd_channel_distribution_pkg::*;
#(
	parameter logic [7:0] OPTION_WORD = 8'h6A
) (
	input wire logic       clk,
	input wire logic       rst_b,
	input wire logic       clkEn,
	input wire logic       serCs_b,
	input wire logic [3:0] rowIdx,
	input wire logic       redChar,
	input wire logic       greenChar,
	input wire logic       blueChar,
	input wire logic       secondaryFlag,
	input wire logic       red_char_out,
	input wire logic       primary_char_out,
	input wire logic       secondary_char_out,
	input wire logic       msbFirst,
	input wire logic       threeLineUnit,
	input wire logic       lcOscSelect
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	a_config_order: assert property (msbFirst == OPTION_WORD[6] && threeLineUnit == OPTION_WORD[5])
		else $error("option decode wrong");
	a_clock_source: assert property (lcOscSelect == OPTION_WORD[1])
		else $error("clock source decode wrong");
	a_rgb_suppress: assert property ($past(rst_b && clkEn) |->
		red_char_out == $past(redChar && !secondaryFlag)) else $error("red not gated by flag");
	a_primary_flag: assert property ($past(rst_b && clkEn && secondaryFlag) |-> !primary_char_out)
		else $error("flagged character on primary");
	a_primary_or: assert property ($past(rst_b && clkEn) && primary_char_out |->
		$past(redChar || greenChar || blueChar)) else $error("primary without colour input");
	a_second_flag: assert property (OPTION_WORD[4] && $past(rst_b && clkEn && !secondaryFlag) |->
		!secondary_char_out) else $error("unflagged character on secondary");
	a_bad_row: assert property (OPTION_WORD[4] && $past(rst_b && clkEn && rowIdx > 4'hB) |->
		!secondary_char_out) else $error("secondary output on invalid row");
	a_chan_apart: assert property (OPTION_WORD[4] |-> !(primary_char_out && secondary_char_out))
		else $error("both channels carry one character");
	c_secondary: cover property (secondary_char_out);
	c_primary: cover property (primary_char_out);
	c_frame: cover property ($fell(serCs_b));
endmodule
bind osd_channel_distribution osd_channel_distribution_checker #(.OPTION_WORD(OPTION_WORD)) u_chk (
	.clk, .rst_b, .clkEn, .serCs_b, .rowIdx, .redChar, .greenChar, .blueChar, .secondaryFlag,
	.red_char_out, .primary_char_out, .secondary_char_out, .msbFirst, .threeLineUnit, .lcOscSelect);

// *** test/osd_ser_ctrl.sv ***
// Controller model that shifts command words into the serial input.
// Assumes most significant bit first; clock idles low between frames.
`timescale 1ns/100ps
module osd_ser_ctrl
	import osd_channel_distribution_pkg::*;
(
	input wire logic clk,
	output logic     serClk,
	output logic     serCs_b,
	output logic     serData
);
	initial begin
		serClk = 1'b0;
		serCs_b = 1'b1;
		serData = 1'b0;
	end
	task automatic send(input logic [15:0] w);
		@(posedge clk) serCs_b <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			@(posedge clk) serData <= w[i];
			@(posedge clk) serClk <= 1'b1;
			@(posedge clk) serClk <= 1'b0;
			@(posedge clk);
		end
		@(posedge clk) serCs_b <= 1'b1;
		serData <= ~w[0];
	endtask
endmodule

// *** test/test_osd_channel_distribution.sv ***
// Testbench for the channel distribution block, option C, three channels.
// Assumes the controller model and the bound checker.
`timescale 1ns/100ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("unexpected %s exp %h seen %h", n, e, g); end end
module test_osd_channel_distribution
	import osd_channel_distribution_pkg::*;
;
	localparam logic [7:0] OPT = 8'h5E;
	localparam logic [7:0] OPT_A = 8'h3A;
	logic        clk, rst_b, hsel, hwrite, sec, bgOn;
	logic [2:0]  rgb;
	logic [3:0]  rowIdx;
	logic [4:0]  colIdx;
	logic [1:0]  htrans;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic        hreadyout, hresp, rgbBlankOut, msbFirst, threeLineUnit, lcOscSelect;
	logic        red_char_out, green_char_out, blue_char_out, primary_char_out;
	logic        primary_blank_out, secondary_char_out, secondary_blank_out;
	logic        serClk, serCs_b, serData;
	logic        priA, secA, msbA;
	int          error_cnt, checks, cyc;
	logic [15:0] bad [3] = '{16'h9CCC, 16'h9DC4, 16'h9CF4};
	osd_ser_ctrl u_osd_ser_ctrl (.clk, .serClk, .serCs_b, .serData);
	osd_channel_distribution #(.OPTION_WORD(OPT)) u_osd_channel_distribution (
		.clk, .rst_b, .clkEn(1'b1), .serClk, .serCs_b, .serData, .rowIdx, .colIdx,
		.redChar(rgb[2]), .greenChar(rgb[1]), .blueChar(rgb[0]), .redBlank(rgb[2]),
		.greenBlank(rgb[1]), .blueBlank(rgb[0]), .secondaryFlag(sec), .backgroundEn(bgOn),
		.background(bgOn), .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .red_char_out, .green_char_out,
		.blue_char_out, .rgbBlankOut, .primary_char_out, .primary_blank_out,
		.secondary_char_out, .secondary_blank_out, .msbFirst, .threeLineUnit, .lcOscSelect);
	// Second copy: least significant bit first, option A, same serial and video inputs
	osd_channel_distribution #(.OPTION_WORD(OPT_A)) u_osd_channel_distribution_lsb (
		.clk, .rst_b, .clkEn(1'b1), .serClk, .serCs_b, .serData, .rowIdx, .colIdx,
		.redChar(rgb[2]), .greenChar(rgb[1]), .blueChar(rgb[0]), .redBlank(rgb[2]),
		.greenBlank(rgb[1]), .blueBlank(rgb[0]), .secondaryFlag(sec), .backgroundEn(bgOn),
		.background(bgOn), .hsel(1'b0), .haddr(32'h0), .htrans(2'h0), .hwrite(1'b0),
		.hsize(3'h2), .hwdata(32'h0), .hready(1'b1), .hrdata(), .hreadyout(), .hresp(),
		.red_char_out(), .green_char_out(), .blue_char_out(), .rgbBlankOut(),
		.primary_char_out(priA), .primary_blank_out(), .secondary_char_out(secA),
		.secondary_blank_out(), .msbFirst(msbA), .threeLineUnit(), .lcOscSelect());
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic test_done();
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			test_done();
		end
	end
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] e, input string n);
		bus(1'b0, a, 32'h0);
		`CHK(n, e, rd)
	endtask
	// Drive one character, compare outputs one clock later
	task automatic vid(input logic [3:0] r, input logic hi, input logic f);
		logic [1:0] sp;
		logic [2:0] c;
		logic       po, so;
		sp = (r < 4'h4) ? r[1:0] : 2'h0;
		c = 3'h1 << (r % 3);
		po = !f && (sp == 2'h0 || (sp == 2'h1 && !hi) || (sp == 2'h2 && hi));
		so = f && (sp == 2'h3 || (sp == 2'h1 && hi) || (sp == 2'h2 && !hi));
		@(posedge clk);
		rowIdx <= r;
		colIdx <= 5'hB + 5'(hi);
		sec <= f;
		rgb <= c;
		@(posedge clk);
		#1;
		`CHK("primary", po, primary_char_out)
		`CHK("primaryBlank", po, primary_blank_out)
		`CHK("secondary", so, secondary_char_out)
		`CHK("secondaryBlank", so, secondary_blank_out)
		`CHK("red", c[2] && !f, red_char_out)
	endtask
	initial begin
		{rst_b, hsel, hwrite, sec, bgOn, htrans, rgb, rowIdx, colIdx} = '0;
		{haddr, hwdata, error_cnt, checks, cyc} = '0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rdchk(32'h0, {24'h0, OPT}, "option");
		`CHK("config", {OPT[6], OPT[5], OPT[1]}, {msbFirst, threeLineUnit, lcOscSelect})
		rdchk(32'h8, 32'h3F, "chCtrl");
		bus(1'b1, 32'h0, 32'hFF);
		rdchk(32'h0, {24'h0, OPT}, "optionRo");
		bus(1'b1, 32'h10, 32'h55);
		rdchk(32'h10, 32'h0, "unmapped");
		for (int r = 0; r < 4; r++) u_osd_ser_ctrl.send({8'h9C, r[1:0], 2'h0, r[3:0]});
		for (int i = 0; i < 3; i++) u_osd_ser_ctrl.send(bad[i]);
		rdchk(32'h4, 32'h000C000A, "rowBits");
		rdchk(32'hC, 32'h00009CCC, "lastCmd");
		u_osd_ser_ctrl.send(16'h8239);
		for (int r = 0; r < 5; r++)
			for (int h = 0; h < 2; h++)
				for (int f = 0; f < 2; f++) vid(r[3:0], h[0], f[0]);
		@(posedge clk);
		rowIdx <= 4'h1;
		sec <= 1'b1;
		rgb <= 3'h4;
		@(posedge clk);
		#1 `CHK("optAFlag", 3'h1, {msbA, priA, secA})
		sec <= 1'b0;
		@(posedge clk);
		#1 `CHK("optAOff", 2'h0, {priA, secA})
		rowIdx <= 4'h0;
		@(posedge clk);
		#1 `CHK("optARow", 2'h2, {priA, secA})
		@(posedge clk);
		rowIdx <= 4'hC;
		sec <= 1'b1;
		rgb <= 3'h7;
		@(posedge clk);
		#1 `CHK("badRow", 1'b0, secondary_char_out)
		bus(1'b1, 32'h8, 32'h3D);
		sec <= 1'b0;
		rowIdx <= 4'h0;
		repeat (2) @(posedge clk);
		#1 `CHK("priOff", 2'h1, {primary_char_out, red_char_out})
		bus(1'b1, 32'h4, 32'h0ABC0123);
		rdchk(32'h4, 32'h0ABC0123, "rowWrite");
		test_done();
	end
endmodule
